// [fcsl_bus_cycle.sv]
`timescale 1ns/10ps
`default_nettype none
`include "fcsl_regs.svh"

module fcsl_bus_cycle #(
  parameter int SETUP_CYC = `FCSL_SETUP_CYC,
  parameter int STROBE_CYC = `FCSL_STROBE_CYC,
  parameter int HOLD_CYC = `FCSL_HOLD_CYC
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic reqValid,
  output logic reqReady,
  input wire fcsl_pkg::fcsl_cyc_s reqCyc,
  input wire logic wordMode,
  output logic rspDone,
  output logic [15:0] rspData,
  output logic [16:0] flashAddr,
  output logic flashAddrM1,
  output logic flashCeN,
  output logic flashOeN,
  output logic flashWeN,
  output logic [15:0] dqOut,
  output logic dqOe,
  input wire logic [15:0] dqIn
);
  fcsl_pkg::fcsl_cyc_e state_ff, nxt_state;
  logic [4:0] cnt_ff, nxt_cnt;
  logic wr_ff, nxt_wr;
  logic [16:0] flashAddr_ff, nxt_flashAddr;
  logic addrM1_ff, nxt_addrM1;
  logic ceN_ff, nxt_ceN, oeN_ff, nxt_oeN, weN_ff, nxt_weN;
  logic [15:0] dqOut_ff, nxt_dqOut;
  logic dqOe_ff, nxt_dqOe;
  logic done_ff, nxt_done;
  logic [15:0] rspData_ff, nxt_rspData;
  logic [15:0] dqMeta_ff, dqSync_ff;

  // pin data arrives asynchronously: two stages before use
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      dqMeta_ff <= 16'h0000;
      dqSync_ff <= 16'h0000;
    end else begin
      dqMeta_ff <= dqIn;
      dqSync_ff <= dqMeta_ff;
    end
  end

  assign reqReady = (state_ff == fcsl_pkg::CY_IDLE);

  // one strobe cycle on the pins
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_wr = wr_ff;
    nxt_flashAddr = flashAddr_ff;
    nxt_addrM1 = addrM1_ff;
    nxt_ceN = ceN_ff;
    nxt_oeN = oeN_ff;
    nxt_weN = weN_ff;
    nxt_dqOut = dqOut_ff;
    nxt_dqOe = dqOe_ff;
    nxt_done = 1'b0;
    nxt_rspData = rspData_ff;
    case (state_ff)
      fcsl_pkg::CY_IDLE: begin
        if (reqValid) begin
          nxt_wr = reqCyc.wr;
          nxt_flashAddr = wordMode ? reqCyc.addr[16:0] : reqCyc.addr[17:1];
          nxt_addrM1 = wordMode ? 1'b0 : reqCyc.addr[0];
          nxt_dqOut = reqCyc.data;
          nxt_dqOe = reqCyc.wr;
          nxt_ceN = 1'b0; // chip enable leads so write enable is the later fall
          nxt_cnt = 5'(SETUP_CYC - 1);
          nxt_state = fcsl_pkg::CY_SETUP;
        end
      end
      fcsl_pkg::CY_SETUP: begin
        if (cnt_ff == 5'h00) begin
          nxt_weN = ~wr_ff; // RULE_25
          nxt_oeN = wr_ff; // RULE_25
          // reads stay open longer to cover the input synchroniser
          nxt_cnt = wr_ff ? 5'(STROBE_CYC - 1) : 5'(STROBE_CYC + `FCSL_SYNC_CYC - 1);
          nxt_state = fcsl_pkg::CY_STROBE;
        end else begin
          nxt_cnt = cnt_ff - 5'h01;
        end
      end
      fcsl_pkg::CY_STROBE: begin
        if (cnt_ff == 5'h00) begin
          if (!wr_ff) begin
            nxt_rspData = dqSync_ff;
          end
          // raising oe and ce between reads makes every read a fresh toggle
          nxt_weN = 1'b1; // RULE_17
          nxt_oeN = 1'b1;
          nxt_ceN = 1'b1;
          nxt_cnt = 5'(HOLD_CYC - 1);
          nxt_state = fcsl_pkg::CY_HOLD;
        end else begin
          nxt_cnt = cnt_ff - 5'h01;
        end
      end
      default: begin
        if (cnt_ff == 5'h00) begin
          nxt_dqOe = 1'b0; // data held past the rising strobe
          nxt_done = 1'b1;
          nxt_state = fcsl_pkg::CY_IDLE;
        end else begin
          nxt_cnt = cnt_ff - 5'h01;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_ff <= fcsl_pkg::CY_IDLE;
      cnt_ff <= 5'h00;
      wr_ff <= 1'b0;
      flashAddr_ff <= 17'h00000;
      addrM1_ff <= 1'b0;
      ceN_ff <= 1'b1;
      oeN_ff <= 1'b1;
      weN_ff <= 1'b1;
      dqOut_ff <= 16'h0000;
      dqOe_ff <= 1'b0;
      done_ff <= 1'b0;
      rspData_ff <= 16'h0000;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      wr_ff <= nxt_wr;
      flashAddr_ff <= nxt_flashAddr;
      addrM1_ff <= nxt_addrM1;
      ceN_ff <= nxt_ceN;
      oeN_ff <= nxt_oeN;
      weN_ff <= nxt_weN;
      dqOut_ff <= nxt_dqOut;
      dqOe_ff <= nxt_dqOe;
      done_ff <= nxt_done;
      rspData_ff <= nxt_rspData;
    end
  end

  assign flashAddr = flashAddr_ff;
  assign flashAddrM1 = addrM1_ff;
  assign flashCeN = ceN_ff;
  assign flashOeN = oeN_ff;
  assign flashWeN = weN_ff;
  assign dqOut = dqOut_ff;
  assign dqOe = dqOe_ff;
  assign rspDone = done_ff;
  assign rspData = rspData_ff;
endmodule

`default_nettype wire

// [fcsl_flash_model.sv]
`timescale 1ns/10ps
`default_nettype none
module fcsl_flash_model #(
  parameter logic [7:0] MFR_ID = 8'h5A, // arbitrary
  parameter logic [7:0] DEV_ID = 8'hC3, // arbitrary
  parameter logic [4:0] PROT_BLK = 5'h1F,
  parameter int BUSY_R = 3
) (
  input wire logic ceN,
  input wire logic oeN,
  input wire logic weN,
  input wire logic wordN,
  input wire logic [16:0] fa,
  input wire logic am1,
  input wire logic [15:0] din,
  output logic [15:0] q,
  output logic qOe
);
  logic [15:0] mem [int];
  logic [16:0] la;
  logic [15:0] k, old;
  logic tog = 1'b0;
  logic fail = 1'b0;
  logic ok, wcy;
  int step = 0, mode = 0, cnt = 0;
  initial q = 16'h0000;
  assign qOe = !ceN && !oeN;
  assign k = wordN ? {la[14:0], am1} : {1'b0, la[14:0]};
  // protected blocks survive an erase
  function void wipe(logic [4:0] b);
    foreach (mem[i]) if (i[16:12] == b && b != PROT_BLK) mem[i] = 16'hFFFF;
  endfunction
  // address taken on the falling write strobe
  always @(negedge weN) if (!ceN && oeN) la = fa;
  always @(negedge weN) wcy = !ceN && oeN;
  // command decode on the rising write strobe; chip enable may rise with it
  always @(posedge weN) if (wcy) begin
    ok = step % 3 == 0 ? din[7:0] == 8'hAA && k == (wordN ? 16'hAAAA : 16'h5555) :
      din[7:0] == 8'h55 && k == (wordN ? 16'h0555 : 16'h2AAA);
    if (mode == 2) begin
      old = mem.exists(la) ? mem[la] : 16'hFFFF;
      mem[la] = old & din;
      fail = |(din & ~old);
      cnt = BUSY_R;
      mode = 0;
    end else if (din[7:0] == 8'hF0) begin
      mode = 0;
      step = 0;
      cnt = 0;
      fail = 1'b0;
    end else if (cnt > 0) begin
      if (din[7:0] == 8'h30) wipe(la[16:12]);
      if (din[7:0] == 8'h30) cnt = BUSY_R;
    end else if (step inside {0, 1, 3, 4}) step = ok ? step + 1 : 0;
    else if (step == 2 && din[7:0] == 8'h80) step = 3;
    else begin
      mode = step == 2 ? (din[7:0] == 8'h90 ? 1 : din[7:0] == 8'hA0 ? 2 : 0) : 0;
      if (step == 5 && din[7:0] == 8'h30) wipe(la[16:12]);
      if (step == 5 && din[7:0] == 8'h30) cnt = BUSY_R;
      step = 0;
    end
  end
  // every read strobe yields a fresh word; status while busy or failed
  always @(negedge oeN or negedge ceN) if (!ceN && !oeN) begin
    if (cnt > 0 || fail) begin
      tog = ~tog;
      if (!fail) cnt = cnt - 1;
      q = {9'h000, tog, fail, 5'h04};
    end else if (mode == 1) q = fa[1] ? {15'h0000, fa[16:12] == PROT_BLK} :
      {8'h00, fa[0] ? DEV_ID : MFR_ID};
    else q = mem.exists(fa) ? mem[fa] : 16'hFFFF;
  end
endmodule
`default_nettype wire

// [fcsl_host.sv]
// Functional notes
// RULE_01: device flips the operation toggle bit on each read while busy.
// RULE_02: two equal toggle reads mean finished; the next read gives final data.
// RULE_03: toggle bit means something only after fourth program or sixth erase write.
// RULE_04: all-protected erase toggles about 100us then returns to array read.
// RULE_05: suspended block reads one on toggle bit; other-block programming toggles it.
// RULE_06: erase-block reads toggle bit 2; other blocks read one or stored data.
// RULE_07: chip erase toggles bit 2; program and done read one except failing block.
// RULE_08: failure flag set on program or erase failure or zero-to-one writes.
// RULE_09: failure flag holds until read/reset; success leaves it at zero.
// RULE_10: erase window flag reads zero 80-120us after last confirm, then one.
// RULE_11: first unlock write is AAh at AAAAh byte or 5555h word.
// RULE_12: second unlock write is 55h at 555h byte or 2AAAh word.
// RULE_13: single F0h write, optionally unlocked, returns device to array read.
// RULE_14: after read/reset during erase, wait 10us before trusting reads.
// RULE_15: after unlock and 90h, address bits pick maker or device code.
// RULE_16: identify mode with bit1 high reads block protection as 01h or 00h.
// RULE_17: program is A0h third, then target; address on fall, data on rise.
// RULE_18: during programming reads give status; only ones become zeros.
// RULE_19: during suspend, programming outside erased blocks toggles bit 2 there.
// RULE_20: block erase: unlock, 80h, unlock, then 30h inside the block.
// RULE_21: extra confirms add blocks without unlock and restart the erase window.
// RULE_22: bad confirm or bad unlock drops the sequence to array read.
// RULE_23: during erase only suspend and read/reset commands are taken.
// RULE_24: unknown write sequences leave the device in array read.
// RULE_25: write cycle is chip and write enable low, output enable high.
`timescale 1ns/10ps
`default_nettype none
`include "fcsl_regs.svh"

module fcsl_host #(
  parameter int SETTLE_CYC = `FCSL_SETTLE_CYC
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [16:0] flashAddr,
  output logic flashAddrM1,
  output logic flashCeN,
  output logic flashOeN,
  output logic flashWeN,
  output logic flashWordModeN,
  output logic [15:0] dqOut,
  output logic dqOe,
  input wire logic [15:0] dqIn
);
  fcsl_pkg::fcsl_host_e state_ff, nxt_state;
  fcsl_pkg::fcsl_op_e op_ff, nxt_op;
  logic wordMode_ff, nxt_wordMode;
  logic [17:0] addrReg_ff, nxt_addrReg;
  logic [15:0] wdataReg_ff, nxt_wdataReg;
  logic [15:0] rdataReg_ff, nxt_rdataReg;
  logic [15:0] prevRd_ff, nxt_prevRd;
  logic [2:0] step_ff, nxt_step;
  logic issued_ff, nxt_issued;
  logic done_ff, nxt_done;
  logic fail_ff, nxt_fail;
  logic eraseActive_ff, nxt_eraseActive;
  logic [13:0] settleCnt_ff, nxt_settleCnt;
  logic [31:0] prdata_ff, nxt_prdata;
  logic pslverr_ff, nxt_pslverr;
  logic reqValid, reqReady, rspDone, apbWr, goReq;
  logic [15:0] rspData;
  fcsl_pkg::fcsl_cyc_s reqCyc;
  logic [2:0] opLen;

  // number of writes each operation puts on the pins
  function automatic logic [2:0] seqLen(input fcsl_pkg::fcsl_op_e op);
    case (op)
      fcsl_pkg::OP_RESET: seqLen = 3'd1;
      fcsl_pkg::OP_IDENT: seqLen = 3'd3;
      fcsl_pkg::OP_PROG: seqLen = 3'd4;
      fcsl_pkg::OP_ERASE: seqLen = 3'd6;
      fcsl_pkg::OP_ERASE_ADD: seqLen = 3'd1;
      default: seqLen = 3'd0;
    endcase
  endfunction

  // address and data of one write within a command sequence
  function automatic fcsl_pkg::fcsl_cyc_s seqWrite(input fcsl_pkg::fcsl_op_e op,
      input logic [2:0] step, input logic wm, input logic [17:0] a, input logic [15:0] d);
    fcsl_pkg::fcsl_cyc_s c;
    logic [17:0] u1;
    logic [17:0] u2;
    u1 = wm ? `FCSL_UNLOCK1_WORD : `FCSL_UNLOCK1_BYTE;
    u2 = wm ? `FCSL_UNLOCK2_WORD : `FCSL_UNLOCK2_BYTE;
    c.wr = 1'b1;
    c.addr = u1;
    c.data = `FCSL_CMD_RESET; // RULE_13
    if (op == fcsl_pkg::OP_ERASE_ADD) begin
      c.addr = a; // RULE_21
      c.data = `FCSL_CMD_ERASE_CONFIRM;
    end else if (op != fcsl_pkg::OP_RESET) begin
      if (step == 3'd0 || step == 3'd3) begin
        c.data = `FCSL_UNLOCK1_DATA; // RULE_11
      end else if (step == 3'd1 || step == 3'd4) begin
        c.addr = u2; // RULE_12
        c.data = `FCSL_UNLOCK2_DATA;
      end else if (step == 3'd2) begin
        if (op == fcsl_pkg::OP_IDENT) begin
          c.data = `FCSL_CMD_IDENT; // RULE_15
        end else if (op == fcsl_pkg::OP_PROG) begin
          c.data = `FCSL_CMD_PROGRAM; // RULE_17
        end else begin
          c.data = `FCSL_CMD_ERASE_SETUP; // RULE_20
        end
      end
      if (op == fcsl_pkg::OP_PROG && step == 3'd3) begin
        c.addr = a; // RULE_17
        c.data = d;
      end else if (step == 3'd5) begin
        c.addr = a; // RULE_20
        c.data = `FCSL_CMD_ERASE_CONFIRM;
      end
    end
    seqWrite = c;
  endfunction

  assign apbWr = psel && penable && pwrite;
  assign goReq = apbWr && (paddr == `FCSL_CTRL_OFS) && pwdata[`FCSL_CTRL_GO_BIT]
                 && (state_ff == fcsl_pkg::HS_IDLE) && (pwdata[3:1] != 3'h7);
  assign opLen = seqLen(fcsl_pkg::fcsl_op_e'(pwdata[`FCSL_CTRL_OP_MSB:`FCSL_CTRL_OP_LSB]));

  // apb read data captured in the setup phase, so the access needs no wait
  always_comb begin
    nxt_prdata = prdata_ff;
    nxt_pslverr = pslverr_ff;
    if (psel && !penable) begin
      nxt_pslverr = 1'b0;
      nxt_prdata = 32'h0000_0000;
      if (paddr == `FCSL_CTRL_OFS) begin
        nxt_prdata = {27'h0, wordMode_ff, op_ff, 1'b0};
      end else if (paddr == `FCSL_ADDR_OFS) begin
        nxt_prdata = {14'h0, addrReg_ff};
      end else if (paddr == `FCSL_WDATA_OFS) begin
        nxt_prdata = {16'h0, wdataReg_ff};
      end else if (paddr == `FCSL_STATUS_OFS) begin
        nxt_prdata = {28'h0, eraseActive_ff, fail_ff, done_ff, state_ff != fcsl_pkg::HS_IDLE};
      end else if (paddr == `FCSL_RDATA_OFS) begin
        nxt_prdata = {16'h0, rdataReg_ff};
      end else begin
        nxt_pslverr = 1'b1;
      end
    end
  end

  assign reqCyc = (state_ff == fcsl_pkg::HS_WRITE || state_ff == fcsl_pkg::HS_RST) ?
                  seqWrite(state_ff == fcsl_pkg::HS_RST ? fcsl_pkg::OP_RESET : op_ff,
                  step_ff, wordMode_ff, addrReg_ff, wdataReg_ff) :
                  fcsl_pkg::fcsl_cyc_s'{wr: 1'b0, addr: addrReg_ff, data: 16'h0000};
  assign reqValid = !issued_ff && (state_ff != fcsl_pkg::HS_IDLE)
                    && (state_ff != fcsl_pkg::HS_SETTLE);

  // sequencer: command writes, toggle polling, recovery
  always_comb begin
    nxt_state = state_ff;
    nxt_op = op_ff;
    nxt_wordMode = wordMode_ff;
    nxt_addrReg = addrReg_ff;
    nxt_wdataReg = wdataReg_ff;
    nxt_rdataReg = rdataReg_ff;
    nxt_prevRd = prevRd_ff;
    nxt_step = step_ff;
    nxt_issued = issued_ff;
    nxt_done = done_ff;
    nxt_fail = fail_ff;
    nxt_eraseActive = eraseActive_ff;
    nxt_settleCnt = settleCnt_ff;
    if (reqValid && reqReady) begin
      nxt_issued = 1'b1;
    end
    if (rspDone) begin
      nxt_issued = 1'b0;
    end
    if (state_ff == fcsl_pkg::HS_IDLE && apbWr) begin
      if (paddr == `FCSL_ADDR_OFS) begin
        nxt_addrReg = pwdata[17:0];
      end else if (paddr == `FCSL_WDATA_OFS) begin
        nxt_wdataReg = pwdata[15:0];
      end else if (paddr == `FCSL_CTRL_OFS) begin
        nxt_wordMode = pwdata[`FCSL_CTRL_WORD_BIT];
      end
    end
    case (state_ff)
      fcsl_pkg::HS_IDLE: begin
        if (goReq) begin
          nxt_op = fcsl_pkg::fcsl_op_e'(pwdata[`FCSL_CTRL_OP_MSB:`FCSL_CTRL_OP_LSB]);
          nxt_done = 1'b0;
          nxt_fail = 1'b0;
          nxt_step = 3'd0;
          if (opLen != 3'd0) begin
            nxt_state = fcsl_pkg::HS_WRITE;
          end else if (nxt_op == fcsl_pkg::OP_WAIT) begin
            nxt_state = fcsl_pkg::HS_RDA;
          end else begin
            nxt_state = fcsl_pkg::HS_FINAL;
          end
        end
      end
      fcsl_pkg::HS_WRITE: begin
        if (rspDone) begin
          nxt_step = step_ff + 3'd1;
          if (nxt_step == seqLen(op_ff)) begin
            if (op_ff == fcsl_pkg::OP_IDENT) begin
              nxt_state = fcsl_pkg::HS_FINAL; // RULE_15
            end else if (op_ff == fcsl_pkg::OP_PROG) begin
              nxt_state = fcsl_pkg::HS_RDA; // RULE_03
            end else if (op_ff == fcsl_pkg::OP_RESET) begin
              nxt_eraseActive = 1'b0;
              // an erase cut short needs time before reads are valid
              nxt_state = eraseActive_ff ? fcsl_pkg::HS_SETTLE : fcsl_pkg::HS_IDLE; // RULE_14
              nxt_settleCnt = 14'(SETTLE_CYC);
              nxt_done = !eraseActive_ff;
            end else begin
              // erase window left open so software may add blocks
              nxt_eraseActive = 1'b1; // RULE_21
              nxt_done = 1'b1;
              nxt_state = fcsl_pkg::HS_IDLE;
            end
          end
        end
      end
      fcsl_pkg::HS_RDA: begin
        if (rspDone) begin
          nxt_prevRd = rspData;
          nxt_state = fcsl_pkg::HS_RDB;
        end
      end
      fcsl_pkg::HS_RDB: begin
        if (rspDone) begin
          nxt_prevRd = rspData;
          if (rspData[`FCSL_OP_TOGGLE_POS] == prevRd_ff[`FCSL_OP_TOGGLE_POS]) begin
            nxt_state = fcsl_pkg::HS_FINAL; // RULE_02
          end else if (rspData[`FCSL_FAILURE_POS]) begin
            nxt_state = fcsl_pkg::HS_RDC; // RULE_08
          end else begin
            nxt_state = fcsl_pkg::HS_RDA; // RULE_01
          end
        end
      end
      fcsl_pkg::HS_RDC: begin
        if (rspDone) begin
          nxt_prevRd = rspData;
          nxt_state = fcsl_pkg::HS_RDD;
        end
      end
      fcsl_pkg::HS_RDD: begin
        // failure flag may rise just as the operation ends: recheck the toggle
        if (rspDone) begin
          if (rspData[`FCSL_OP_TOGGLE_POS] == prevRd_ff[`FCSL_OP_TOGGLE_POS]) begin
            nxt_state = fcsl_pkg::HS_FINAL; // RULE_02
          end else begin
            nxt_fail = 1'b1; // RULE_09
            nxt_step = 3'd0;
            nxt_state = fcsl_pkg::HS_RST;
          end
        end
      end
      fcsl_pkg::HS_FINAL: begin
        if (rspDone) begin
          nxt_rdataReg = rspData; // RULE_02
          nxt_done = 1'b1;
          if (op_ff == fcsl_pkg::OP_WAIT) begin
            nxt_eraseActive = 1'b0;
          end
          nxt_state = fcsl_pkg::HS_IDLE;
        end
      end
      fcsl_pkg::HS_RST: begin
        // the flag only clears with a read/reset, so send one after a failure
        if (rspDone) begin
          nxt_eraseActive = 1'b0;
          nxt_settleCnt = 14'(SETTLE_CYC);
          nxt_state = fcsl_pkg::HS_SETTLE; // RULE_14
        end
      end
      default: begin
        if (settleCnt_ff == 14'h0000) begin
          nxt_done = 1'b1;
          nxt_state = fcsl_pkg::HS_IDLE;
        end else begin
          nxt_settleCnt = settleCnt_ff - 14'h0001;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_ff <= fcsl_pkg::HS_IDLE;
      op_ff <= fcsl_pkg::OP_READ;
      wordMode_ff <= 1'b0;
      addrReg_ff <= 18'h00000;
      wdataReg_ff <= 16'h0000;
      rdataReg_ff <= 16'h0000;
      prevRd_ff <= 16'h0000;
      step_ff <= 3'd0;
      issued_ff <= 1'b0;
      done_ff <= 1'b0;
      fail_ff <= 1'b0;
      eraseActive_ff <= 1'b0;
      settleCnt_ff <= 14'h0000;
      prdata_ff <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      op_ff <= nxt_op;
      wordMode_ff <= nxt_wordMode;
      addrReg_ff <= nxt_addrReg;
      wdataReg_ff <= nxt_wdataReg;
      rdataReg_ff <= nxt_rdataReg;
      prevRd_ff <= nxt_prevRd;
      step_ff <= nxt_step;
      issued_ff <= nxt_issued;
      done_ff <= nxt_done;
      fail_ff <= nxt_fail;
      eraseActive_ff <= nxt_eraseActive;
      settleCnt_ff <= nxt_settleCnt;
      prdata_ff <= nxt_prdata;
      pslverr_ff <= nxt_pslverr;
    end
  end

  fcsl_bus_cycle u_cycle (
    .sys_clk(sys_clk),
    .rst(rst),
    .reqValid(reqValid),
    .reqReady(reqReady),
    .reqCyc(reqCyc),
    .wordMode(wordMode_ff),
    .rspDone(rspDone),
    .rspData(rspData),
    .flashAddr(flashAddr),
    .flashAddrM1(flashAddrM1),
    .flashCeN(flashCeN),
    .flashOeN(flashOeN),
    .flashWeN(flashWeN),
    .dqOut(dqOut),
    .dqOe(dqOe),
    .dqIn(dqIn)
  );

  assign prdata = prdata_ff;
  assign pslverr = pslverr_ff;
  assign pready = 1'b1;
  assign flashWordModeN = ~wordMode_ff;
endmodule

`default_nettype wire

// [fcsl_host_checker.sv]
`timescale 1ns/10ps
`default_nettype none
module fcsl_host_checker (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [16:0] flashAddr,
  input wire logic flashAddrM1,
  input wire logic flashCeN,
  input wire logic flashOeN,
  input wire logic flashWeN,
  input wire logic [15:0] dqOut,
  input wire logic dqOe
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // strobe qualification, so the device never sees a false write or bus fight
  property p_wr_qual; !flashWeN |-> !flashCeN && flashOeN && dqOe; endproperty
  a_wr_qual: assert property (p_wr_qual) else $error("write strobe outside write cycle");
  property p_rd_qual; !flashOeN |-> !flashCeN && flashWeN && !dqOe; endproperty
  a_rd_qual: assert property (p_rd_qual) else $error("read strobe outside read cycle");
  // write pulse shape: address settled before the fall, data held past the rise
  property p_we_len; $fell(flashWeN) |-> !flashWeN[*7] ##1 flashWeN; endproperty
  a_we_len: assert property (p_we_len) else $error("write pulse width wrong");
  property p_we_setup; $fell(flashWeN) |-> !$past(flashCeN) && !$past(flashCeN, 2); endproperty
  a_we_setup: assert property (p_we_setup) else $error("no setup before write");
  property p_d_hold; $rose(flashWeN) |-> dqOe && $stable(dqOut) ##1 dqOe && $stable(dqOut); endproperty
  a_d_hold: assert property (p_d_hold) else $error("write data not held");
  property p_a_hold; !flashCeN && !$past(flashCeN) |-> $stable(flashAddr) && $stable(flashAddrM1);
  endproperty
  a_a_hold: assert property (p_a_hold) else $error("address moved in cycle");
  // each read is its own strobe, so the toggle bit advances once per read
  property p_oe_len; $fell(flashOeN) |-> !flashOeN[*8] ##1 !flashOeN ##1 flashOeN; endproperty
  a_oe_len: assert property (p_oe_len) else $error("read pulse width wrong");
  property p_gap; $rose(flashCeN) |=> flashCeN && flashOeN && flashWeN; endproperty
  a_gap: assert property (p_gap) else $error("no idle gap between cycles");
endmodule
bind fcsl_host fcsl_host_checker i_fcsl_host_checker (.sys_clk(sys_clk), .rst(rst),
  .flashAddr(flashAddr), .flashAddrM1(flashAddrM1), .flashCeN(flashCeN), .flashOeN(flashOeN),
  .flashWeN(flashWeN), .dqOut(dqOut), .dqOe(dqOe));
`default_nettype wire

// [fcsl_pkg.sv]
package fcsl_pkg;

  typedef enum logic [2:0] {
    OP_READ,
    OP_RESET,
    OP_IDENT,
    OP_PROG,
    OP_ERASE,
    OP_ERASE_ADD,
    OP_WAIT
  } fcsl_op_e;

  typedef enum logic [3:0] {
    HS_IDLE,
    HS_WRITE,
    HS_RDA,
    HS_RDB,
    HS_RDC,
    HS_RDD,
    HS_FINAL,
    HS_RST,
    HS_SETTLE
  } fcsl_host_e;

  typedef enum logic [1:0] {
    CY_IDLE,
    CY_SETUP,
    CY_STROBE,
    CY_HOLD
  } fcsl_cyc_e;

  typedef struct packed {
    logic wr;
    logic [17:0] addr;
    logic [15:0] data;
  } fcsl_cyc_s;

endpackage

// [fcsl_regs.svh]
`ifndef FCSL_REGS_SVH
`define FCSL_REGS_SVH

// clock and timing
`define FCSL_CLK_PERIOD_NS 10
`define FCSL_T_SETUP_NS 20
`define FCSL_SETUP_CYC ((`FCSL_T_SETUP_NS + `FCSL_CLK_PERIOD_NS - 1) / `FCSL_CLK_PERIOD_NS)
`define FCSL_T_STROBE_NS 70
`define FCSL_STROBE_CYC ((`FCSL_T_STROBE_NS + `FCSL_CLK_PERIOD_NS - 1) / `FCSL_CLK_PERIOD_NS)
`define FCSL_T_HOLD_NS 20
`define FCSL_HOLD_CYC ((`FCSL_T_HOLD_NS + `FCSL_CLK_PERIOD_NS - 1) / `FCSL_CLK_PERIOD_NS)
`define FCSL_SYNC_CYC 2
`define FCSL_T_SETTLE_US 10
`define FCSL_SETTLE_CYC ((`FCSL_T_SETTLE_US * 1000 + `FCSL_CLK_PERIOD_NS - 1) / `FCSL_CLK_PERIOD_NS)

// apb register offsets
`define FCSL_CTRL_OFS 12'h000
`define FCSL_ADDR_OFS 12'h004
`define FCSL_WDATA_OFS 12'h008
`define FCSL_STATUS_OFS 12'h00C
`define FCSL_RDATA_OFS 12'h010

// control fields
`define FCSL_CTRL_GO_BIT 0
`define FCSL_CTRL_OP_LSB 1
`define FCSL_CTRL_OP_MSB 3
`define FCSL_CTRL_WORD_BIT 4
`define FCSL_CTRL_RESET 32'h0000_0000

// status fields
`define FCSL_ST_BUSY_BIT 0
`define FCSL_ST_DONE_BIT 1
`define FCSL_ST_FAIL_BIT 2
`define FCSL_ST_ERASE_BIT 3

// flash status bit positions
`define FCSL_OP_TOGGLE_POS 6
`define FCSL_FAILURE_POS 5

// unlock addresses and command codes
`define FCSL_UNLOCK1_BYTE 18'h0AAAA
`define FCSL_UNLOCK1_WORD 18'h05555
`define FCSL_UNLOCK2_BYTE 18'h00555
`define FCSL_UNLOCK2_WORD 18'h02AAA
`define FCSL_UNLOCK1_DATA 16'h00AA
`define FCSL_UNLOCK2_DATA 16'h0055
`define FCSL_CMD_RESET 16'h00F0
`define FCSL_CMD_IDENT 16'h0090
`define FCSL_CMD_PROGRAM 16'h00A0
`define FCSL_CMD_ERASE_SETUP 16'h0080
`define FCSL_CMD_ERASE_CONFIRM 16'h0030

`endif

// [test_flash_command_status_logic.sv]
`timescale 1ns/10ps
`default_nettype none
module test_flash_command_status_logic;
  localparam logic [7:0] MFR = 8'h5A; // arbitrary
  localparam logic [7:0] DEV = 8'hC3; // arbitrary
  localparam logic [4:0] PBLK = 5'h1F;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, wm = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata, r, st, exp;
  logic pready, pslverr, err, ceN, oeN, weN, wordN, am1, dqOe, mOe;
  logic [16:0] fa, wa;
  logic [15:0] dqOut, mq, dqIn, wd, old;
  int bad_count = 0, check_count = 0;
  int refMem [int];
  int addrs [$];
  // released bus shows the inverse
  assign dqIn = dqOe ? dqOut : (mOe ? mq : ~mq);
  fcsl_host #(.SETTLE_CYC(20)) i_fcsl_host (.sys_clk(sys_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .flashAddr(fa), .flashAddrM1(am1), .flashCeN(ceN),
    .flashOeN(oeN), .flashWeN(weN), .flashWordModeN(wordN), .dqOut(dqOut), .dqOe(dqOe),
    .dqIn(dqIn));
  fcsl_flash_model #(.MFR_ID(MFR), .DEV_ID(DEV), .PROT_BLK(PBLK)) i_fcsl_flash_model (.ceN(ceN),
    .oeN(oeN), .weN(weN), .wordN(wordN), .fa(fa), .am1(am1), .din(dqIn), .q(mq), .qOe(mOe));
  initial forever #5 sys_clk = ~sys_clk;
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  // one apb transfer, then an idle cycle
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  // load address and data, start, poll until idle, fetch final read
  task automatic op(input int o, input logic [17:0] a, input logic [15:0] d);
    int n;
    n = 0;
    apb(1'b1, 12'h004, {14'h0000, a});
    apb(1'b1, 12'h008, {16'h0000, d});
    apb(1'b1, 12'h000, {27'h0000000, wm, o[2:0], 1'b1});
    do begin
      apb(1'b0, 12'h00C, 32'h00000000);
      n++;
    end while (r[0] && n < 2000);
    st = r;
    chk("busy", 0, st[0]);
    chk("done", 1, st[1]);
    apb(1'b0, 12'h010, 32'h00000000);
  endtask
  task automatic sweep();
    foreach (refMem[a]) begin
      op(0, 18'(a), 16'h0000);
      chk("array", refMem[a], r);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #900000;
    bad_count++;
    give_verdict();
  end
  initial begin
    void'($urandom(52749));
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    apb(1'b0, 12'h000, 32'h00000000);
    chk("ctrl", 0, r);
    apb(1'b0, 12'h00C, 32'h00000000);
    chk("status", 0, r);
    apb(1'b1, 12'h020, 32'hFFFFFFFF);
    chk("unmapped", 1, err);
    $display("test registers done");
    for (int m = 0; m < 2; m++) begin
      wm = m[0];
      for (int s = 0; s < 4; s++) begin
        wa = s == 3 ? {PBLK, 12'h002} : s == 2 ? 17'h01002 : 17'(s);
        op(2, {1'b0, wa} << (1 - m), 16'h0000);
        exp = s == 0 ? MFR : s == 1 ? DEV : s == 3;
        chk("ident", exp, r[7:0]);
      end
    end
    op(1, 18'h00000, 16'h0000);
    op(0, 18'h00002, 16'h0000);
    chk("reset", 32'h0000FFFF, r);
    $display("test identify done");
    for (int i = 0; i < 8; i++) begin
      if (i % 2 == 0) wa = 17'($urandom_range(0, 32'h1EFFF));
      if (i % 2 == 0) addrs.push_back(wa);
      wd = 16'($urandom);
      old = 16'(refMem.exists(wa) ? refMem[wa] : 32'h0000FFFF);
      op(3, {1'b0, wa}, wd);
      refMem[wa] = old & wd;
      if ((wd & ~old) != 16'h0000) chk("fail", 1, st[2]);
      else chk("program", old & wd, r);
    end
    sweep();
    $display("test program done");
    op(4, 18'(addrs[0]), 16'h0000);
    op(5, 18'(addrs[1]), 16'h0000);
    op(6, 18'h00000, 16'h0000);
    foreach (refMem[a]) if (a[16:12] == addrs[0][16:12] || a[16:12] == addrs[1][16:12])
      refMem[a] = 32'h0000FFFF;
    sweep();
    $display("test erase done");
    give_verdict();
  end
endmodule
`default_nettype wire
